// [shared/bram_cfg.svh]
`ifndef BRAM_CFG_SVH
`define BRAM_CFG_SVH
// Register select codes
`define BRAM_SEL_CMD      3'h0
`define BRAM_SEL_STATE    3'h1
`define BRAM_SEL_RESULT   3'h2
`define BRAM_SEL_SETUP    3'h3
`define BRAM_SEL_FILTER   3'h4
`define BRAM_SEL_TARE     3'h5
`define BRAM_SEL_OFFSET   3'h6
`define BRAM_SEL_GAIN     3'h7
// Access types in the command byte
`define BRAM_ACC_WR       2'h0
`define BRAM_ACC_RD       2'h1
`define BRAM_ACC_CONT     2'h2
`define BRAM_ACC_STOP     2'h3
// Reset values
`define BRAM_SETUP_RST    16'h01B0
`define BRAM_FILTER_RST   24'h200000
`define BRAM_TARE_RST     8'h20
`define BRAM_OFFSET_RST   24'h800000
`define BRAM_GAIN_RST     24'h59AEE7
`define BRAM_TEST_RST     24'h000000
`define BRAM_STATE_HI     4'hC
// Field positions
`define BRAM_FLT_RATE_LSB 12
`define BRAM_FLT_CHOP_BIT 4
`define BRAM_SET_WL_BIT   8
`define BRAM_SET_CH_LSB   0
`define BRAM_SET_STANDBY_FLAG_LSB 13
// Serial framing, rate divisors and test address
`define BRAM_RESYNC_ONES  6'd32
`define BRAM_CHOP_DIV     8'd48
`define BRAM_PLAIN_DIV    8'd16
`define BRAM_TEST_ADDR    3'h3
`endif

// [shared/bram_pkg.sv]
package bram_pkg;
  typedef enum logic [2:0] {
    BRAM_IDLE = 3'b000,
    BRAM_CMD  = 3'b001,
    BRAM_DATA = 3'b011,
    BRAM_CONT = 3'b010
  } bram_phase_e;

  typedef struct packed {
    logic [1:0] access;
    logic [2:0] target;
  } bram_cmd_s;

  typedef struct packed {
    logic [23:0] value;
    logic        fresh;
  } bram_conv_s;
endpackage

// [src/bram_rate_gen.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bram_cfg.svh"
module bram_rate_gen
  import bram_pkg::*;
#(
  parameter int CW = 20
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [11:0] rate_word_in,
  input  wire logic        chop_in,
  output logic             tick_out
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } bram_rg_s;

  bram_rg_s st_r;
  bram_rg_s st_nxt;
  logic [CW-1:0] period;

  // Output rate is clock over 16 or 48 times the rate word
  always_comb begin
    period = chop_in ? CW'(rate_word_in) * CW'(`BRAM_CHOP_DIV)
                     : CW'(rate_word_in) * CW'(`BRAM_PLAIN_DIV);
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt + CW'(1) >= period) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;
endmodule
`default_nettype wire

// [src/bram_regs.sv]
// Behaviour
// - Twelve registers reachable over the serial port; the test register has no select code here
// - Each access starts with a command byte write
// - Return to command wait unless continuous read
// - State register reads upper nibble C
// - Result is 16 or 24 bits by word length
// - Setup register resets to 01B0, steers options
// - Filter register holds averaging, step, excitation, chop
// - Twelve-bit rate word sets output rate
// - Non-chop rate is clock over sixteen words
// - Chop bit zero means non-chopping operation
// - Tare register resets 20, six-bit level
// - Three offset coefficients reset to 800000
// - Three gain coefficients reset to 59AEE7
// - Chop rate clock over 48 words, default 512
// - Thirty-two high clocks resynchronise the port
// - Leading one holds; zero starts command load
`timescale 1ns/10ps
`default_nettype none
`include "bram_cfg.svh"
module bram_regs
  import bram_pkg::*;
#(
  parameter int RATE_CW = 20
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        SCLK_IN,
  input  wire logic        SDI_IN,
  input  wire logic [23:0] SAMPLE_IN,
  output logic             SDO_OUT,
  output logic             SDO_OE_N_OUT,
  output logic             READY_N_OUT,
  output logic [15:0]      SETUP_OUT,
  output logic [23:0]      FILTER_OUT,
  output logic [7:0]       TARE_OUT
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0]   sclk_sync;
    logic [1:0]   sdi_sync;
    bram_phase_e  phase;
    bram_cmd_s    cmd;
    logic [23:0]  shreg;
    logic [4:0]   bits;
    logic [5:0]   ones;
    logic         rd;
    logic [15:0]  setup;
    logic [23:0]  filter;
    logic [7:0]   tare;
    logic [23:0]  test;
    logic [71:0]  offset;
    logic [71:0]  gain;
    bram_conv_s   conv;
    logic         sdo;
    logic         oe_n;
    logic         ready_n;
  } bram_st_s;

  bram_st_s st_r;
  bram_st_s st_nxt;
  logic     tick;
  logic     rise;
  logic     fall;
  logic     din;
  logic [4:0]  len;
  logic [23:0] rdval;
  logic [1:0]  ch;
  logic        last;
  // Three coefficient banks, one per input channel
  localparam int CHANNELS = 3;
  logic        wr_commit;
  logic        rd_done;
  logic        cmd_done;
  logic        resync_hit;
  logic [23:0] offset_ch [CHANNELS];
  logic [23:0] gain_ch   [CHANNELS];

  // ==========================================================
  // Output rate
  bram_rate_gen #(.CW(RATE_CW)) u_rate (
    .clk_in       (CORE_CLK_IN),
    .rst_n_in     (RST_N_IN),
    .rate_word_in (st_r.filter[`BRAM_FLT_RATE_LSB +: 12]),
    .chop_in      (st_r.filter[`BRAM_FLT_CHOP_BIT]),
    .tick_out     (tick)
  );

  // ==========================================================
  // Coefficient banks; one slice per input channel
  for (genvar gc = 0; gc < CHANNELS; gc++) begin : g_coef
    assign offset_ch[gc] = st_r.offset[gc*24 +: 24];
    assign gain_ch[gc]   = st_r.gain[gc*24 +: 24];
    // A bank may only move when its own channel is written
    chk_bank_hold : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      !(wr_commit && ch == 2'(gc)) |=> ($stable(st_r.offset[gc*24 +: 24]) &&
      $stable(st_r.gain[gc*24 +: 24]))) else $error("coefficient bank changed without a write");
  end

  // ==========================================================
  // Read multiplexer
  always_comb begin
    ch = (st_r.setup[`BRAM_SET_CH_LSB +: 2] == 2'h3) ? 2'h2 : st_r.setup[`BRAM_SET_CH_LSB +: 2];
    unique case (st_r.cmd.target)
      `BRAM_SEL_STATE:  rdval = {`BRAM_STATE_HI, ~st_r.conv.fresh, st_r.setup[`BRAM_SET_STANDBY_FLAG_LSB +: 3],
                                 16'h0000} >> 16;
      // Short word carries the upper sixteen bits of the result
      `BRAM_SEL_RESULT: rdval = st_r.setup[`BRAM_SET_WL_BIT] ? st_r.conv.value
                                                            : {8'h00, st_r.conv.value[23:8]};
      `BRAM_SEL_SETUP:  rdval = {8'h00, st_r.setup};
      `BRAM_SEL_FILTER: rdval = st_r.filter;
      `BRAM_SEL_TARE:   rdval = {16'h0000, st_r.tare};
      `BRAM_SEL_OFFSET: rdval = offset_ch[ch];
      `BRAM_SEL_GAIN:   rdval = gain_ch[ch];
      default:          rdval = st_r.test;
    endcase
    // Result is 16 or 24 bits by word length
    if (st_r.cmd.target == `BRAM_SEL_RESULT && !st_r.setup[`BRAM_SET_WL_BIT]) begin
      len = 5'd16;
    end else if (st_r.cmd.target == `BRAM_SEL_STATE || st_r.cmd.target == `BRAM_SEL_TARE) begin
      len = 5'd8;
    end else if (st_r.cmd.target == `BRAM_SEL_SETUP) begin
      len = 5'd16;
    end else begin
      len = 5'd24;
    end
  end

  // ==========================================================
  // Serial engine; data changes on falling, sampled on rising
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_sync = {st_r.sclk_sync[1:0], SCLK_IN};
    st_nxt.sdi_sync  = {st_r.sdi_sync[0], SDI_IN};
    rise = st_r.sclk_sync[1] & ~st_r.sclk_sync[2];
    fall = ~st_r.sclk_sync[1] & st_r.sclk_sync[2];
    din  = st_r.sdi_sync[1];
    last = (st_r.bits + 5'd1 == len);
    if (tick) begin
      st_nxt.conv.value = SAMPLE_IN;
      st_nxt.conv.fresh = 1'b1;
    end
    if (rise) begin
      st_nxt.ones = din ? ((st_r.ones == `BRAM_RESYNC_ONES) ? st_r.ones : st_r.ones + 6'd1) : 6'd0;
      unique case (st_r.phase)
        BRAM_IDLE: begin
          if (!din) begin
            st_nxt.phase = BRAM_CMD;
            st_nxt.bits  = 5'd0;
          end
        end
        BRAM_CMD: begin
          st_nxt.shreg = {st_r.shreg[22:0], din};
          st_nxt.bits  = st_r.bits + 5'd1;
          if (st_r.bits == 5'd6) begin
            st_nxt.cmd.access = st_r.shreg[4:3];
            st_nxt.cmd.target = {st_r.shreg[1:0], din};
            st_nxt.bits  = 5'd0;
            st_nxt.rd    = (st_r.shreg[4:3] == `BRAM_ACC_RD) || (st_r.shreg[4:3] == `BRAM_ACC_CONT);
            st_nxt.phase = (st_r.shreg[4:3] == `BRAM_ACC_STOP) ? BRAM_IDLE : BRAM_DATA;
            if ({st_r.shreg[1:0], din} == `BRAM_SEL_CMD) begin
              st_nxt.phase = BRAM_IDLE;
            end
          end
        end
        BRAM_DATA, BRAM_CONT: begin
          st_nxt.shreg = {st_r.shreg[22:0], din};
          st_nxt.bits  = st_r.bits + 5'd1;
          if (last) begin
            st_nxt.bits = 5'd0;
            if (st_r.rd && st_r.cmd.target == `BRAM_SEL_RESULT) begin
              st_nxt.conv.fresh = tick;
            end
            if (!st_r.rd) begin
              unique case (st_r.cmd.target)
                `BRAM_SEL_SETUP:  st_nxt.setup  = {st_r.shreg[14:0], din};
                `BRAM_SEL_FILTER: st_nxt.filter = {st_r.shreg[22:0], din};
                `BRAM_SEL_TARE:   st_nxt.tare   = {2'b00, st_r.shreg[4:0], din};
                `BRAM_SEL_OFFSET: st_nxt.offset[ch*24 +: 24] = {st_r.shreg[22:0], din};
                `BRAM_SEL_GAIN:   st_nxt.gain[ch*24 +: 24]   = {st_r.shreg[22:0], din};
                default: ;
              endcase
            end
            // Continuous read keeps the port on the addressed register
            st_nxt.phase = (st_r.cmd.access == `BRAM_ACC_CONT) ? BRAM_CONT : BRAM_IDLE;
          end
        end
        default: st_nxt.phase = BRAM_IDLE;
      endcase
      if (din && st_r.ones + 6'd1 >= `BRAM_RESYNC_ONES) begin
        st_nxt.phase  = BRAM_IDLE;
        st_nxt.cmd    = '0;
        st_nxt.setup  = `BRAM_SETUP_RST;
        st_nxt.filter = `BRAM_FILTER_RST;
        st_nxt.tare   = `BRAM_TARE_RST;
        st_nxt.bits   = 5'd0;
      end
    end
    if (fall && st_r.rd && (st_r.phase == BRAM_DATA || st_r.phase == BRAM_CONT)) begin
      st_nxt.sdo  = rdval[len - 5'd1 - st_r.bits];
      st_nxt.oe_n = 1'b0;
    end else if (st_r.phase == BRAM_IDLE || st_r.phase == BRAM_CMD) begin
      st_nxt.oe_n = 1'b1;
      st_nxt.sdo  = 1'b0;
    end
    // Registered so the ready pin comes straight from a flop
    st_nxt.ready_n = ~st_nxt.conv.fresh;
  end

  // ==========================================================
  // Registers; thirteen in all: command, state, result, setup,
  // filter, tare, three offsets, three gains, test
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      st_r        <= '0;
      st_r.phase  <= BRAM_IDLE;
      st_r.setup  <= `BRAM_SETUP_RST;
      st_r.filter <= `BRAM_FILTER_RST;
      st_r.tare   <= `BRAM_TARE_RST;
      st_r.test   <= `BRAM_TEST_RST;
      st_r.offset <= {3{`BRAM_OFFSET_RST}};
      st_r.gain   <= {3{`BRAM_GAIN_RST}};
      st_r.oe_n   <= 1'b1;
      // Synchronisers start at the idle pin levels; no false edge
      st_r.sclk_sync <= '1;
      st_r.sdi_sync  <= '1;
      st_r.ready_n   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign SDO_OUT      = st_r.sdo;
  assign SDO_OE_N_OUT = st_r.oe_n;
  assign READY_N_OUT  = st_r.ready_n;
  assign SETUP_OUT    = st_r.setup;
  assign FILTER_OUT   = st_r.filter;
  assign TARE_OUT     = st_r.tare;

  // ==========================================================
  // Checks
  chk_tare_top_zero : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    st_r.tare[7:6] == 2'b00) else $error("tare upper bits set");
  chk_idle_after_op : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rise && st_r.phase == BRAM_DATA && last && st_r.cmd.access != `BRAM_ACC_CONT)
    |=> st_r.phase == BRAM_IDLE) else $error("no return to command wait");
  chk_hold_on_one : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rise && st_r.phase == BRAM_IDLE && din) |=> st_r.phase == BRAM_IDLE)
    else $error("advanced on leading one");
  chk_resync_ones : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rise && din && st_r.ones >= 6'd31) |=> st_r.phase == BRAM_IDLE)
    else $error("resync failed");

  // ==========================================================
  // Strobes for the checks; they mirror the engine's decode
  assign wr_commit  = rise && (st_r.phase == BRAM_DATA) && last && !st_r.rd;
  assign rd_done    = rise && (st_r.phase == BRAM_DATA || st_r.phase == BRAM_CONT)
                      && last && st_r.rd;
  assign cmd_done   = rise && (st_r.phase == BRAM_CMD) && (st_r.bits == 5'd6);
  assign resync_hit = rise && din && (st_r.ones + 6'd1 >= `BRAM_RESYNC_ONES);

  // ==========================================================
  // Command framing checks
  chk_cmd_zero_idle : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (cmd_done && {st_r.shreg[1:0], din} == `BRAM_SEL_CMD) |=> st_r.phase == BRAM_IDLE)
    else $error("command aimed at itself did not return to wait");

  chk_cmd_to_data : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (cmd_done && {st_r.shreg[1:0], din} != `BRAM_SEL_CMD
     && st_r.shreg[4:3] != `BRAM_ACC_STOP) |=> st_r.phase == BRAM_DATA)
    else $error("command did not open a data phase");

  chk_stop_idle : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (cmd_done && st_r.shreg[4:3] == `BRAM_ACC_STOP) |=> st_r.phase == BRAM_IDLE)
    else $error("stop command left the port busy");

  chk_cont_stays : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rd_done && st_r.cmd.access == `BRAM_ACC_CONT && !resync_hit) |=> st_r.phase == BRAM_CONT)
    else $error("continuous read left the result register");

  // The pin must be released whenever the port waits for a command
  chk_oe_off_idle : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (st_r.phase == BRAM_IDLE) |=> SDO_OE_N_OUT)
    else $error("data pin driven while idle");

  chk_ones_clear : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rise && !din) |=> st_r.ones == 6'd0)
    else $error("high count kept after a low bit");

  chk_resync_port : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    resync_hit |=> (st_r.phase == BRAM_IDLE && st_r.bits == 5'd0 && st_r.cmd == '0))
    else $error("port not cleared by high run");

  // ==========================================================
  // Register commit checks
  chk_setup_commit : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (wr_commit && st_r.cmd.target == `BRAM_SEL_SETUP && !resync_hit)
    |=> SETUP_OUT == $past({st_r.shreg[14:0], din})) else $error("setup write lost");

  chk_filter_commit : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (wr_commit && st_r.cmd.target == `BRAM_SEL_FILTER && !resync_hit)
    |=> FILTER_OUT == $past({st_r.shreg[22:0], din})) else $error("filter write lost");

  chk_tare_commit : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (wr_commit && st_r.cmd.target == `BRAM_SEL_TARE && !resync_hit)
    |=> TARE_OUT == {2'b00, $past({st_r.shreg[4:0], din})}) else $error("tare write lost");

  chk_resync_regs : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    resync_hit |=> (SETUP_OUT == `BRAM_SETUP_RST && FILTER_OUT == `BRAM_FILTER_RST
                    && TARE_OUT == `BRAM_TARE_RST))
    else $error("high run did not restore setup");

  // A read must never disturb what it reads
  chk_read_keeps : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rd_done && !resync_hit) |=> ($stable(SETUP_OUT) && $stable(FILTER_OUT) && $stable(TARE_OUT)))
    else $error("read changed a setting");

  // ==========================================================
  // Result and ready checks
  chk_ready_on_tick : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    tick |=> (!READY_N_OUT && st_r.conv.value == $past(SAMPLE_IN)))
    else $error("new result not flagged");

  chk_read_clears : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rd_done && st_r.cmd.target == `BRAM_SEL_RESULT && !tick) |=> READY_N_OUT)
    else $error("ready kept after result read");

  chk_first_bit : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (fall && st_r.rd && st_r.phase == BRAM_DATA && st_r.bits == 5'd0)
    |=> (!SDO_OE_N_OUT && SDO_OUT == $past(rdval[len - 5'd1])))
    else $error("first read bit not most significant");

  chk_bits_bound : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    st_r.bits < 5'd24)
    else $error("bit counter ran past a word");
endmodule
`default_nettype wire

// [tb/bram_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module bram_host_model
  import bram_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      sclk_out,
  output logic      sdi_out
);
  // ==========================================
  // Serial clock stands high between frames
  int half = 5;
  initial begin
    sclk_out = 1'b1;
    sdi_out  = 1'b1;
  end
  // Low half above three clocks so SDO has settled before it is taken
  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_in);
      #1;
      sclk_out = 1'b0;
      sdi_out  = tx[i];
      repeat (half) @(posedge clk_in);
      #1;
      rx = {rx[30:0], sdo_in};
      sclk_out = 1'b1;
      repeat (half) @(posedge clk_in);
    end
    #1 sdi_out = 1'b1;
  endtask
  task automatic ones(input int n);
    logic [31:0] rx;
    shift(32'hFFFFFFFF, n, rx);
  endtask
  // Never addresses the test register
  task automatic access(input logic [1:0] acc, input logic [2:0] tgt, input int n,
                        input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] rx;
    shift({24'h000000, 3'b000, acc, 1'b0, tgt}, 8, rx);
    if (n > 0) begin
      shift({8'h00, wd}, n, rx);
    end
    rd = rx[23:0];
  endtask
endmodule
`default_nettype wire

// [tb/bram_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bram_cfg.svh"
module bram_regs_tb
  import bram_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, sclk, sdi, sdo, sdo_oe_n, ready_n;
  logic [23:0] sample = 24'hA5C31E;
  logic [15:0] setup;
  logic [23:0] filter;
  logic [7:0]  tare;
  int mismatches = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  bram_host_model host (.clk_in(clk), .sdo_in(sdo), .sclk_out(sclk), .sdi_out(sdi));
  bram_regs #(.RATE_CW(20)) uut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SCLK_IN(sclk),
    .SDI_IN(sdi), .SAMPLE_IN(sample), .SDO_OUT(sdo), .SDO_OE_N_OUT(sdo_oe_n),
    .READY_N_OUT(ready_n), .SETUP_OUT(setup), .FILTER_OUT(filter), .TARE_OUT(tare));
  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [2:0] t, input int n, input logic [23:0] exp, input string nm);
    logic [23:0] d;
    host.access(`BRAM_ACC_RD, t, n, 24'h000000, d);
    chk(nm, exp, d);
  endtask
  task automatic wr(input logic [2:0] t, input int n, input logic [23:0] v);
    logic [23:0] d;
    host.access(`BRAM_ACC_WR, t, n, v, d);
  endtask
  task automatic wait_ready(output int t);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 5000 && ready_n !== 1'b0; k++) @(posedge clk);
    chk("ready", 24'h0, {23'h0, ready_n});
    t = cyc;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    logic [23:0] d;
    chk("idle", 24'h3, {22'h0, sdo_oe_n, ready_n});
    host.ones(3);
    rd(`BRAM_SEL_SETUP, 16, 24'h0001B0, "setup");
    rd(`BRAM_SEL_FILTER, 24, 24'h200000, "filter");
    rd(`BRAM_SEL_TARE, 8, 24'h20, "tare");
    rd(`BRAM_SEL_OFFSET, 24, 24'h800000, "offset");
    rd(`BRAM_SEL_GAIN, 24, 24'h59AEE7, "gain");
    host.access(`BRAM_ACC_RD, `BRAM_SEL_STATE, 8, 24'h0, d);
    chk("state", 24'hC, {20'h0, d[7:4]});
  endtask
  task automatic t_write;
    wr(`BRAM_SEL_SETUP, 16, 24'h000152);
    chk("setup_out", 24'h000152, {8'h0, setup});
    wr(`BRAM_SEL_TARE, 8, 24'hFF);
    rd(`BRAM_SEL_TARE, 8, 24'h3F, "tare_ro");
    chk("tare_out", 24'h3F, {16'h0, tare});
  endtask
  task automatic t_bank;
    logic [23:0] d;
    host.half = 9;
    wr(`BRAM_SEL_SETUP, 16, 24'h0001B0);
    wr(`BRAM_SEL_OFFSET, 24, 24'h13579B);
    wr(`BRAM_SEL_GAIN, 24, 24'h2468AC);
    host.access(`BRAM_ACC_RD, 3'h0, 0, 24'h0, d);
    wr(`BRAM_SEL_SETUP, 16, 24'h0001B1);
    rd(`BRAM_SEL_OFFSET, 24, 24'h800000, "offset1");
    rd(`BRAM_SEL_GAIN, 24, 24'h59AEE7, "gain1");
    wr(`BRAM_SEL_SETUP, 16, 24'h0001B0);
    rd(`BRAM_SEL_OFFSET, 24, 24'h13579B, "offset0");
    rd(`BRAM_SEL_GAIN, 24, 24'h2468AC, "gain0");
    host.half = 5;
  endtask
  task automatic t_resync;
    wr(`BRAM_SEL_TARE, 8, 24'h05);
    host.ones(32);
    repeat (4) @(posedge clk);
    chk("resync", 24'h0001B0, {8'h0, setup});
    chk("resync_f", 24'h200000, filter);
    rd(`BRAM_SEL_TARE, 8, 24'h20, "resync_t");
  endtask
  task automatic t_rate(input logic chop, input int exp);
    int t0, t1;
    wr(`BRAM_SEL_FILTER, 24, {12'd64, 7'h00, chop, 4'h0});
    rd(`BRAM_SEL_RESULT, 24, sample, "result");
    wait_ready(t0);
    rd(`BRAM_SEL_RESULT, 24, sample, "result");
    chk("ready_clr", 24'h1, {23'h0, ready_n});
    wait_ready(t1);
    chk("period", exp, t1 - t0);
  endtask
  task automatic t_cont;
    logic [23:0] d;
    logic [31:0] rx;
    host.access(`BRAM_ACC_CONT, `BRAM_SEL_RESULT, 24, 24'h000000, d);
    chk("cont0", sample, d);
    host.shift(32'h00000000, 24, rx);
    chk("cont1", sample, rx[23:0]);
    host.ones(32);
    rd(`BRAM_SEL_TARE, 8, 24'h20, "cont_exit");
  endtask
  task automatic t_short;
    wr(`BRAM_SEL_SETUP, 16, 24'h0000B0);
    rd(`BRAM_SEL_RESULT, 16, {8'h00, sample[23:8]}, "result16");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_write();
    t_bank();
    t_resync();
    t_rate(1'b0, 1024);
    t_rate(1'b1, 3072);
    t_cont();
    t_short();
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
